//--- design/tof_cmd_status.sv
// Command interpreter and status registers of the host register map
// Behaviour
// (R1) New address in bits 7:1, bit 0 zero
// (R2) Address change only when masked pins match
// (R3) Commands 0x80-0x93 select channel and quarter
// (R4) End of quarter read refills result area
// (R5) Each refill updates tag and identifier
// (R6) Channel advances after its last quarter
// (R7) Abort command stops measurement, returns idle
// (R8) Abort waits until processing state ends
// (R9) Last command register shows executed command
// (R10) Status 00h-0Fh ok, 10h-FFh error
// (R11) Tag tells what result area holds
// (R12) Tags 0Ah calib, 47h serial, 55h results
// (R13) Tags 80h-93h are histogram quarters
// (R14) Identifier changes on every map update
// (R15) Read-only registers ignore writes, pair updates
`timescale 1ns/1ns
`default_nettype none
module tof_cmd_status
    import tof_cmd_pkg::*;
(
    // Clock and reset
    input wire logic mclk_in,
    input wire logic rst_b_in,
    // Register port from the serial bus front end
    input wire logic [7:0] reg_addr_in,
    input wire logic [7:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    input wire logic xfer_end_in,
    output logic [7:0] reg_rdata_out,
    // General-purpose pins
    input wire logic gpio0_pin_in,
    input wire logic gpio1_pin_in,
    // Application side
    input wire logic proc_busy_in,
    input wire logic [7:0] app_status_in,
    input wire logic app_status_load_in,
    input wire logic [7:0] app_tag_in,
    input wire logic app_tag_load_in,
    output logic [7:0] cmd_code_out,
    output logic cmd_strobe_out,
    output logic measure_stop_out,
    output logic hist_load_out,
    output logic [2:0] hist_channel_out,
    output logic [1:0] hist_quarter_out,
    output logic [6:0] dev_addr_out
);
    logic pin0_level;
    logic pin1_level;
    ctrl_state_t state_reg, state_next;
    logic [7:0] arg_first_reg, arg_first_next;
    logic [7:0] arg_second_reg, arg_second_next;
    logic [7:0] last_cmd_code_reg, last_cmd_code_next;
    logic [7:0] status_reg, status_next;
    logic [7:0] tag_reg, tag_next;
    logic [7:0] tid_reg, tid_next;
    logic [7:0] cmd_code_reg, cmd_code_next;
    logic [6:0] dev_addr_reg, dev_addr_next;
    logic [7:0] rdata_reg, rdata_next;
    logic seen_reg, seen_next;
    logic strobe_reg, strobe_next;
    logic stop_reg, stop_next;
    logic load_reg, load_next;
    logic cmd_wr;
    logic is_hist_cmd;
    logic pins_match;
    logic hist_read_hit;
    logic refill_go;

    // Pins come from outside the clock domain
    pin_sync u_sync0 (
        .mclk_in(mclk_in),
        .rst_b_in(rst_b_in),
        .pin_in(gpio0_pin_in),
        .level_out(pin0_level)
    );
    pin_sync u_sync1 (
        .mclk_in(mclk_in),
        .rst_b_in(rst_b_in),
        .pin_in(gpio1_pin_in),
        .level_out(pin1_level)
    );

    // Decoded events
    assign cmd_wr = reg_wr_in && (reg_addr_in == ADDR_COMMAND);
    // (R3) histogram command range
    assign is_hist_cmd = (reg_wdata_in >= CMD_HIST_FIRST) && (reg_wdata_in <= CMD_HIST_LAST);
    // (R2) masked pin compare
    assign pins_match = ((arg_first_reg[MASK_MSB:MASK_LSB] & {pin1_level, pin0_level})
        == arg_first_reg[VALUE_MSB:VALUE_LSB]);
    assign hist_read_hit = reg_rd_in && (state_reg == ST_STREAM)
        && (reg_addr_in >= ADDR_RESULT_FIRST) && (reg_addr_in <= ADDR_HIST_LAST);
    // (R4) refill at end of a transaction that read the area
    assign refill_go = (state_reg == ST_STREAM) && xfer_end_in && (seen_reg || hist_read_hit);

    // Next-state logic for all control and register state
    always_comb begin
        state_next = state_reg;
        arg_first_next = arg_first_reg;
        arg_second_next = arg_second_reg;
        last_cmd_code_next = last_cmd_code_reg;
        status_next = status_reg;
        tag_next = tag_reg;
        tid_next = tid_reg;
        cmd_code_next = cmd_code_reg;
        dev_addr_next = dev_addr_reg;
        rdata_next = rdata_reg;
        strobe_next = 1'b0;
        stop_next = 1'b0;
        load_next = 1'b0;
        // Read set wins over the end-of-transfer clear
        seen_next = hist_read_hit ? 1'b1 : (xfer_end_in ? 1'b0 : seen_reg);
        // (R10) status reported by the application
        if (app_status_load_in) begin
            status_next = app_status_in;
        end
        // (R12) application tags result area; (R14) identifier moves with it
        if (app_tag_load_in) begin
            tag_next = app_tag_in;
            tid_next = tid_reg + 8'h01;
        end
        // (R15) only argument and command locations are writable
        if (reg_wr_in && reg_addr_in == ADDR_ARG_FIRST) begin
            arg_first_next = reg_wdata_in;
        end
        if (reg_wr_in && reg_addr_in == ADDR_ARG_SECOND) begin
            arg_second_next = reg_wdata_in;
        end
        unique case (state_reg)
            ST_IDLE, ST_STREAM: begin
                // (R4) refill with next quarter; (R5) tag and identifier together
                if (refill_go) begin
                    seen_next = 1'b0;
                    if (tag_reg == CMD_HIST_LAST) begin
                        state_next = ST_IDLE;
                    end else begin
                        // (R6) tag carry advances the channel
                        tag_next = tag_reg + 8'h01;
                        tid_next = tid_reg + 8'h01;
                        load_next = 1'b1;
                    end
                end
                if (cmd_wr) begin
                    if (reg_wdata_in == CMD_ABORT) begin
                        // (R8) defer while processing is busy
                        if (proc_busy_in) begin
                            state_next = ST_ABORT_WAIT;
                        end else begin
                            // (R7) stop and return idle
                            state_next = ST_IDLE;
                            stop_next = 1'b1;
                            last_cmd_code_next = CMD_ABORT;
                        end
                    end else if (reg_wdata_in == CMD_ADDR_CHANGE) begin
                        // (R9) record executed command
                        last_cmd_code_next = reg_wdata_in;
                        // (R1) nonzero bit 0 is refused as an error
                        if (arg_second_reg[ARG_ZERO_BIT]) begin
                            status_next = STATUS_ADDR_ERROR;
                        end else begin
                            status_next = STATUS_OK;
                            // (R2) apply only on pin match
                            if (pins_match) begin
                                dev_addr_next = arg_second_reg[ARG_ADDR_MSB:ARG_ADDR_LSB];
                            end
                        end
                    end else if (is_hist_cmd) begin
                        // (R3) start stream; (R13) tag names channel and quarter
                        last_cmd_code_next = reg_wdata_in;
                        tag_next = reg_wdata_in;
                        tid_next = tid_reg + 8'h01;
                        load_next = 1'b1;
                        seen_next = 1'b0;
                        state_next = ST_STREAM;
                    end else begin
                        // Other commands go to the application
                        last_cmd_code_next = reg_wdata_in;
                        cmd_code_next = reg_wdata_in;
                        strobe_next = 1'b1;
                    end
                end
            end
            ST_ABORT_WAIT: begin
                // (R8) abort lands when processing leaves its state
                if (!proc_busy_in) begin
                    state_next = ST_IDLE;
                    stop_next = 1'b1;
                    last_cmd_code_next = CMD_ABORT;
                end
            end
            default: begin
                state_next = ST_IDLE;
            end
        endcase
        // (R11) read mux; result area data is served elsewhere, reads zero here
        if (reg_rd_in) begin
            unique case (reg_addr_in)
                ADDR_ARG_SECOND: rdata_next = arg_second_reg;
                ADDR_ARG_FIRST: rdata_next = arg_first_reg;
                ADDR_COMMAND: rdata_next = cmd_code_reg;
                ADDR_LAST_CMD: rdata_next = last_cmd_code_reg;
                ADDR_MINOR_REV: rdata_next = FW_MINOR_REV;
                ADDR_PATCH_REV: rdata_next = FW_PATCH_REV;
                ADDR_STATUS: rdata_next = status_reg;
                ADDR_TAG: rdata_next = tag_reg;
                ADDR_TID: rdata_next = tid_reg;
                default: rdata_next = BYTE_RESET;
            endcase
        end
    end

    // Register all state
    always_ff @(posedge mclk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            state_reg <= ST_IDLE;
            arg_first_reg <= BYTE_RESET;
            arg_second_reg <= BYTE_RESET;
            last_cmd_code_reg <= BYTE_RESET;
            status_reg <= BYTE_RESET;
            tag_reg <= BYTE_RESET;
            tid_reg <= BYTE_RESET;
            cmd_code_reg <= BYTE_RESET;
            dev_addr_reg <= DEV_ADDR_RESET;
            rdata_reg <= BYTE_RESET;
            seen_reg <= 1'b0;
            strobe_reg <= 1'b0;
            stop_reg <= 1'b0;
            load_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            arg_first_reg <= arg_first_next;
            arg_second_reg <= arg_second_next;
            last_cmd_code_reg <= last_cmd_code_next;
            status_reg <= status_next;
            tag_reg <= tag_next;
            tid_reg <= tid_next;
            cmd_code_reg <= cmd_code_next;
            dev_addr_reg <= dev_addr_next;
            rdata_reg <= rdata_next;
            seen_reg <= seen_next;
            strobe_reg <= strobe_next;
            stop_reg <= stop_next;
            load_reg <= load_next;
        end
    end

    // Outputs straight from flip-flops; channel and quarter decode the tag
    assign reg_rdata_out = rdata_reg;
    assign cmd_code_out = cmd_code_reg;
    assign cmd_strobe_out = strobe_reg;
    assign measure_stop_out = stop_reg;
    assign hist_load_out = load_reg;
    assign hist_channel_out = tag_reg[HIST_CH_MSB:HIST_CH_LSB];
    assign hist_quarter_out = tag_reg[HIST_Q_MSB:HIST_Q_LSB];
    assign dev_addr_out = dev_addr_reg;

    // Checks on the command and status behaviour
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (!rst_b_in);

    a_refill_tid_step: assert property ( // (R5)
        (refill_go && tag_reg != CMD_HIST_LAST && !cmd_wr) |=> (tid_reg == $past(tid_reg) + 8'h01) && hist_load_out)
        else $error("refill did not step identifier");
    a_refill_tag_next: assert property ( // (R4)
        (refill_go && tag_reg != CMD_HIST_LAST && !cmd_wr) |=> tag_reg == $past(tag_reg) + 8'h01)
        else $error("refill did not advance tag");
    a_channel_wrap: assert property ( // (R6)
        (refill_go && tag_reg != CMD_HIST_LAST && !cmd_wr && hist_quarter_out == QUARTER_LAST)
        |=> (hist_channel_out == $past(hist_channel_out) + 3'h1) && (hist_quarter_out == 2'h0))
        else $error("channel did not advance after last quarter");
    a_hist_start: assert property ( // (R3)
        (cmd_wr && is_hist_cmd && state_reg != ST_ABORT_WAIT)
        |=> tag_reg == $past(reg_wdata_in) ##1 state_reg == ST_STREAM)
        else $error("histogram command not taken");
    a_abort_defer: assert property ( // (R8)
        (state_reg == ST_ABORT_WAIT && proc_busy_in) |=> !measure_stop_out && state_reg != ST_IDLE)
        else $error("abort cut processing short");
    a_abort_idle: assert property ( // (R7)
        (cmd_wr && reg_wdata_in == CMD_ABORT && !proc_busy_in && state_reg != ST_ABORT_WAIT)
        |=> measure_stop_out && state_reg == ST_IDLE && last_cmd_code_reg == CMD_ABORT)
        else $error("abort did not return idle");
    a_last_cmd: assert property ( // (R9)
        (cmd_wr && reg_wdata_in != CMD_ABORT && state_reg != ST_ABORT_WAIT)
        |=> last_cmd_code_reg == $past(reg_wdata_in))
        else $error("last command not recorded");
    a_status_ro: assert property ( // (R15)
        (reg_wr_in && reg_addr_in == ADDR_STATUS && !app_status_load_in) |=> $stable(status_reg))
        else $error("status changed by host write");
    a_addr_cond: assert property ( // (R2)
        (cmd_wr && reg_wdata_in == CMD_ADDR_CHANGE && state_reg != ST_ABORT_WAIT && !pins_match)
        |=> $stable(dev_addr_out))
        else $error("address changed without pin match");
    a_addr_error: assert property ( // (R10)
        (cmd_wr && reg_wdata_in == CMD_ADDR_CHANGE && state_reg != ST_ABORT_WAIT
        && arg_second_reg[ARG_ZERO_BIT] && !app_status_load_in) |=> status_reg >= STATUS_ERROR_FIRST)
        else $error("bad address not flagged");

    c_refill: cover property (refill_go ##1 hist_load_out);
    c_stream_end: cover property (refill_go && tag_reg == CMD_HIST_LAST ##1 state_reg == ST_IDLE);
    c_abort_wait: cover property (state_reg == ST_ABORT_WAIT ##[1:20] measure_stop_out);
    c_addr_change: cover property (cmd_wr && reg_wdata_in == CMD_ADDR_CHANGE ##1 $changed(dev_addr_out));
endmodule : tof_cmd_status
`default_nettype wire

//--- include/tof_cmd_pkg.sv
// Package: register map, command codes, field positions and states of the command/status block
package tof_cmd_pkg;
    // Register offsets
    localparam logic [7:0] ADDR_ARG_SECOND = 8'h0E;
    localparam logic [7:0] ADDR_ARG_FIRST = 8'h0F;
    localparam logic [7:0] ADDR_COMMAND = 8'h10;
    localparam logic [7:0] ADDR_LAST_CMD = 8'h11;
    localparam logic [7:0] ADDR_MINOR_REV = 8'h12;
    localparam logic [7:0] ADDR_PATCH_REV = 8'h13;
    localparam logic [7:0] ADDR_STATUS = 8'h1D;
    localparam logic [7:0] ADDR_TAG = 8'h1E;
    localparam logic [7:0] ADDR_TID = 8'h1F;
    localparam logic [7:0] ADDR_RESULT_FIRST = 8'h20;
    localparam logic [7:0] ADDR_HIST_LAST = 8'h9F;
    localparam logic [7:0] ADDR_RESULT_LAST = 8'hEF;
    // Command codes
    localparam logic [7:0] CMD_ADDR_CHANGE = 8'h49;
    localparam logic [7:0] CMD_HIST_FIRST = 8'h80;
    localparam logic [7:0] CMD_HIST_LAST = 8'h93;
    localparam logic [7:0] CMD_ABORT = 8'hFF;
    // Result area tags
    localparam logic [7:0] TAG_CALIB = 8'h0A;
    localparam logic [7:0] TAG_SERIAL = 8'h47;
    localparam logic [7:0] TAG_RESULTS = 8'h55;
    // Status codes
    localparam logic [7:0] STATUS_OK = 8'h00;
    localparam logic [7:0] STATUS_ERROR_FIRST = 8'h10;
    localparam logic [7:0] STATUS_ADDR_ERROR = 8'h10;
    // Field positions
    localparam int ARG_ADDR_MSB = 7;
    localparam int ARG_ADDR_LSB = 1;
    localparam int ARG_ZERO_BIT = 0;
    localparam int MASK_LSB = 0;
    localparam int MASK_MSB = 1;
    localparam int VALUE_LSB = 2;
    localparam int VALUE_MSB = 3;
    localparam int HIST_CH_MSB = 4;
    localparam int HIST_CH_LSB = 2;
    localparam int HIST_Q_MSB = 1;
    localparam int HIST_Q_LSB = 0;
    // Reset values and fixed constants
    localparam logic [7:0] BYTE_RESET = 8'h00;
    localparam logic [6:0] DEV_ADDR_RESET = 7'h41;  // Arbitrary value
    localparam logic [7:0] FW_MINOR_REV = 8'h01;    // Arbitrary value
    localparam logic [7:0] FW_PATCH_REV = 8'h02;    // Arbitrary value
    localparam logic [1:0] QUARTER_LAST = 2'h3;
    // Control states
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_STREAM = 3'b010,
        ST_ABORT_WAIT = 3'b100
    } ctrl_state_t;
endpackage : tof_cmd_pkg

//--- design/pin_sync.sv
// Two-flop synchroniser for one asynchronous pin
`timescale 1ns/1ns
`default_nettype none
module pin_sync (
    // Clock and reset
    input wire logic mclk_in,
    input wire logic rst_b_in,
    // Pin and synchronised level
    input wire logic pin_in,
    output logic level_out
);
    logic meta_reg;
    logic meta_next;
    logic level_reg;
    logic level_next;

    // First stage feeds only the second stage
    always_comb begin
        meta_next = pin_in;
        level_next = meta_reg;
    end

    // Register both stages
    always_ff @(posedge mclk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            meta_reg <= 1'b0;
            level_reg <= 1'b0;
        end else begin
            meta_reg <= meta_next;
            level_reg <= level_next;
        end
    end

    assign level_out = level_reg;
endmodule : pin_sync
`default_nettype wire

//--- tb/host_model.sv
// Host controller model driving the register port of the command block
`timescale 1ns/1ns
`default_nettype none
module host_model
    import tof_cmd_pkg::*;
(
    // Clock
    input wire logic mclk_in,
    // Register port toward the block
    output logic [7:0] reg_addr_out,
    output logic [7:0] reg_wdata_out,
    output logic reg_wr_out,
    output logic reg_rd_out,
    output logic xfer_end_out
);
    // Idle bus at time zero
    initial begin
        reg_addr_out = 8'h00;
        reg_wdata_out = 8'h00;
        reg_wr_out = 1'b0;
        reg_rd_out = 1'b0;
        xfer_end_out = 1'b0;
    end

    // One byte per strobe; idle lines show the inverse so a stale value never looks valid
    task automatic access(input logic [7:0] a, input logic [7:0] d, input logic w);
        @(negedge mclk_in);
        reg_addr_out = a;
        reg_wdata_out = d;
        reg_wr_out = w;
        reg_rd_out = !w;
        @(negedge mclk_in);
        reg_wr_out = 1'b0;
        reg_rd_out = 1'b0;
        reg_addr_out = ~a;
        reg_wdata_out = ~d;
    endtask : access

    // Stop condition closes the transaction
    task automatic stop_cond();
        @(negedge mclk_in);
        xfer_end_out = 1'b1;
        @(negedge mclk_in);
        xfer_end_out = 1'b0;
    endtask : stop_cond

    // condition byte, address bits 7:1
    // Bit 0 is set only when a refusal is wanted
    task automatic change_addr(input logic [3:0] cond, input logic [6:0] a, input logic bad);
        access(ADDR_ARG_FIRST, {4'h0, cond}, 1'b1);
        access(ADDR_ARG_SECOND, {a, bad}, 1'b1);
        access(ADDR_COMMAND, CMD_ADDR_CHANGE, 1'b1);
    endtask : change_addr
endmodule : host_model
`default_nettype wire

//--- tb/tb_tof_cmd_status.sv
// Self-checking testbench of the command and status block
`timescale 1ns/1ns
`default_nettype none
module tb_tof_cmd_status;
    import tof_cmd_pkg::*;
    logic mclk_in, rst_b_in, reg_wr_in, reg_rd_in, xfer_end_in, gpio0_pin_in, gpio1_pin_in, proc_busy_in;
    logic [7:0] reg_addr_in, reg_wdata_in, reg_rdata_out, app_status_in, app_tag_in, cmd_code_out;
    logic app_status_load_in, app_tag_load_in, cmd_strobe_out, measure_stop_out, hist_load_out;
    logic [2:0] hist_channel_out;
    logic [1:0] hist_quarter_out;
    logic [6:0] dev_addr_out, a1;
    logic [7:0] exp_rd[$];
    logic [7:0] exp_hl[$];
    logic [7:0] exp_cmd[$];
    logic [7:0] tid_exp = 8'h00;
    logic [7:0] ro_list[4] = '{ADDR_LAST_CMD, ADDR_STATUS, ADDR_TAG, ADDR_TID};
    logic [7:0] tag_list[3] = '{TAG_CALIB, TAG_SERIAL, TAG_RESULTS};
    logic rd_seen = 1'b0;
    int failures = 0;
    int checks = 0;
    int stops = 0;

    tof_cmd_status u_dut (.mclk_in(mclk_in), .rst_b_in(rst_b_in), .reg_addr_in(reg_addr_in),
        .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .xfer_end_in(xfer_end_in),
        .reg_rdata_out(reg_rdata_out), .gpio0_pin_in(gpio0_pin_in), .gpio1_pin_in(gpio1_pin_in),
        .proc_busy_in(proc_busy_in), .app_status_in(app_status_in), .app_status_load_in(app_status_load_in),
        .app_tag_in(app_tag_in), .app_tag_load_in(app_tag_load_in), .cmd_code_out(cmd_code_out),
        .cmd_strobe_out(cmd_strobe_out), .measure_stop_out(measure_stop_out), .hist_load_out(hist_load_out),
        .hist_channel_out(hist_channel_out), .hist_quarter_out(hist_quarter_out), .dev_addr_out(dev_addr_out));
    host_model u_host (.mclk_in(mclk_in), .reg_addr_out(reg_addr_in), .reg_wdata_out(reg_wdata_in),
        .reg_wr_out(reg_wr_in), .reg_rd_out(reg_rd_in), .xfer_end_out(xfer_end_in));

    // 20 MHz clock
    initial begin
        mclk_in = 1'b0;
        forever #25 mclk_in = ~mclk_in;
    end

    task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
        checks++;
        if (got !== exp) begin
            failures++;
            $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask : check

    task automatic conclude();
        if (exp_rd.size() != 0 || exp_hl.size() != 0 || exp_cmd.size() != 0) begin
            failures++;
            $display("mismatch at %0t: expected results left unseen", $time);
        end
        if (failures == 0 && checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : conclude

    // Note the expected byte, then let the host read it
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
        exp_rd.push_back(e);
        u_host.access(a, 8'h00, 1'b0);
    endtask : rd_chk

    // Application side load; a tag load also moves the identifier on
    task automatic app_load(input logic is_tag, input logic [7:0] v);
        @(negedge mclk_in);
        app_status_in = v;
        app_tag_in = v;
        app_tag_load_in = is_tag;
        app_status_load_in = !is_tag;
        @(negedge mclk_in);
        app_tag_load_in = 1'b0;
        app_status_load_in = 1'b0;
        if (is_tag) begin
            tid_exp++;
        end
    endtask : app_load

    // Histogram command with its expected load, tag and identifier
    task automatic hist_cmd(input logic [7:0] c);
        exp_hl.push_back(c);
        tid_exp++;
        u_host.access(ADDR_COMMAND, c, 1'b1);
        rd_chk(ADDR_TAG, c);
        rd_chk(ADDR_TID, tid_exp);
        rd_chk(ADDR_LAST_CMD, c);
    endtask : hist_cmd

    // One transaction: optional result read, then stop; go says whether a refill is due
    task automatic refill(input logic rd, input logic go, input logic [7:0] t);
        if (go) begin
            exp_hl.push_back(t);
            tid_exp++;
        end
        if (rd) begin
            rd_chk(ADDR_RESULT_FIRST, BYTE_RESET);
        end
        u_host.stop_cond();
        rd_chk(ADDR_TAG, t);
        rd_chk(ADDR_TID, tid_exp);
    endtask : refill

    // Read data is valid the cycle after the read edge; load pulses stand one cycle
    always @(posedge mclk_in) rd_seen <= reg_rd_in;
    always @(negedge mclk_in) begin
        if (rd_seen) begin
            check(reg_rdata_out, exp_rd.pop_front(), "read data");
        end
        // Channel and quarter are the low five bits of the expected tag
        if (hist_load_out === 1'b1) begin
            check({3'h0, hist_channel_out, hist_quarter_out}, exp_hl.pop_front() & 8'h1F, "refill");
        end
        if (cmd_strobe_out === 1'b1) begin
            check(cmd_code_out, exp_cmd.pop_front(), "forwarded command");
        end
        if (measure_stop_out === 1'b1) begin
            stops++;
        end
    end

    // Watchdog, well beyond the length of the sequence
    initial begin
        #(50 * 20000);
        failures++;
        $display("mismatch at %0t: watchdog expired", $time);
        conclude();
    end

    initial begin
        void'($urandom(32'h25EF9D73));
        {rst_b_in, gpio0_pin_in, gpio1_pin_in, proc_busy_in} = 4'h0;
        {app_status_in, app_tag_in, app_status_load_in, app_tag_load_in} = 18'h0;
        repeat (5) @(negedge mclk_in);
        rst_b_in = 1'b1;
        check({1'b0, dev_addr_out}, {1'b0, DEV_ADDR_RESET}, "reset address");
        rd_chk(ADDR_MINOR_REV, FW_MINOR_REV);
        rd_chk(ADDR_PATCH_REV, FW_PATCH_REV);
        // Read-only registers reset to zero and keep it under writes
        foreach (ro_list[i]) begin
            rd_chk(ro_list[i], BYTE_RESET);
            u_host.access(ro_list[i], 8'($urandom), 1'b1);
            rd_chk(ro_list[i], BYTE_RESET);
        end
        // Status in the ok range and in the error range
        for (int i = 0; i < 2; i++) begin
            a1 = 7'($urandom);
            app_load(1'b0, {i[0], 3'h0, a1[3:0]} | {3'h0, i[0], 4'h0});
            rd_chk(ADDR_STATUS, {i[0], 3'h0, a1[3:0]} | {3'h0, i[0], 4'h0});
        end
        // Every named content tag, each paired with a fresh identifier
        foreach (tag_list[i]) begin
            app_load(1'b1, tag_list[i]);
            rd_chk(ADDR_TAG, tag_list[i]);
            rd_chk(ADDR_TID, tid_exp);
        end
        // Address change: unconditional, pins match, pins differ, bad bit 0
        gpio0_pin_in = 1'b1;
        repeat (3) @(negedge mclk_in);
        a1 = 7'($urandom);
        u_host.change_addr(4'h0, a1, 1'b0);
        @(negedge mclk_in);
        check({1'b0, dev_addr_out}, {1'b0, a1}, "free address change");
        a1 = ~a1;
        u_host.change_addr(4'b0111, a1, 1'b0);
        @(negedge mclk_in);
        check({1'b0, dev_addr_out}, {1'b0, a1}, "matched address change");
        u_host.change_addr(4'b1011, ~a1, 1'b0);
        rd_chk(ADDR_STATUS, STATUS_OK);
        u_host.change_addr(4'h0, ~a1, 1'b1);
        rd_chk(ADDR_STATUS, STATUS_ADDR_ERROR);
        check({1'b0, dev_addr_out}, {1'b0, a1}, "refused address change");
        // Forwarded command: random code kept clear of the codes handled here
        a1 = 7'($urandom) & 7'h3F;
        exp_cmd.push_back({1'b0, a1});
        u_host.access(ADDR_COMMAND, {1'b0, a1}, 1'b1);
        rd_chk(ADDR_COMMAND, {1'b0, a1});
        rd_chk(ADDR_LAST_CMD, {1'b0, a1});
        // Every histogram quarter command, then no refill past the last one
        for (int c = 8'h80; c <= 8'h93; c++) begin
            hist_cmd(8'(c));
        end
        refill(1'b1, 1'b0, CMD_HIST_LAST);
        // Stream across a channel boundary; a stop with no result read gives no refill
        hist_cmd(8'h8E);
        refill(1'b1, 1'b1, 8'h8F);
        refill(1'b1, 1'b1, 8'h90);
        refill(1'b0, 1'b0, 8'h90);
        // Abort deferred while processing runs
        proc_busy_in = 1'b1;
        u_host.access(ADDR_COMMAND, CMD_ABORT, 1'b1);
        repeat (4) @(negedge mclk_in);
        check(8'(stops), 8'h00, "early stop");
        rd_chk(ADDR_LAST_CMD, 8'h8E);
        proc_busy_in = 1'b0;
        repeat (3) @(negedge mclk_in);
        check(8'(stops), 8'h01, "stop pulse");
        rd_chk(ADDR_LAST_CMD, CMD_ABORT);
        refill(1'b1, 1'b0, 8'h90);
        // Abort with processing idle lands on the next cycle
        u_host.access(ADDR_COMMAND, CMD_ABORT, 1'b1);
        @(negedge mclk_in);
        check(8'(stops), 8'h02, "direct stop");
        repeat (2) @(negedge mclk_in);
        conclude();
    end
endmodule : tb_tof_cmd_status
`default_nettype wire
